//--- common/ipua_pkg.sv
// Purpose: Constants for the integer pack, unpack and sum datapath slice
// Assumes: Octal opcodes, 60-bit words, bit 59 is the sign
// Notes:   Shared by the datapath module and the bench; the register-bank module does not use it
package ipua_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W   = 60;
  localparam int unsigned ADDR_W   = 18;
  localparam int unsigned DSG_W    = 3;
  localparam int unsigned OPC_W    = 6;
  localparam int unsigned OPC9_W   = 9;
  localparam int unsigned SHMSK_W  = 6;
  localparam int unsigned IMM_W    = 18;
  localparam int unsigned PARCEL_W = 15;
  localparam int unsigned LONG_W   = 30;
  localparam int unsigned COEF_W   = 48;
  localparam int unsigned EXP_W    = 11;
  // ----------------------------------------------------------------
  // Field positions in a 30-bit instruction word, sign and exponent in a 60-bit word
  // ----------------------------------------------------------------
  localparam int unsigned OPC_LSB  = 24;
  localparam int unsigned I_LSB    = 21;
  localparam int unsigned J_LSB    = 18;
  localparam int unsigned K_LSB    = 15;
  localparam int unsigned SIGN_BIT = 59;
  localparam int unsigned EXP_LSB  = 48;
  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [5:0] OPC_UNPACK  = 6'h16;   // Octal 26
  localparam logic [5:0] OPC_PACK    = 6'h17;   // Octal 27
  localparam logic [5:0] OPC_IADD    = 6'h1e;   // Octal 36
  localparam logic [5:0] OPC_ISUB    = 6'h1f;   // Octal 37
  localparam logic [5:0] OPC_EXCH    = 6'h01;   // Leading 6 bits of octal 013
  localparam logic [2:0] OPC_EXCH_LO = 3'h3;    // Third octal digit of 013
  // Exponent bias, octal 2000
  localparam logic [10:0] EXP_BIAS   = 11'h400;
  // Reset values
  localparam logic [59:0] X_RESET    = 60'h0;
  localparam logic [17:0] AB_RESET   = 18'h0;
endpackage

//--- verilog/ipua_regbank.sv
// Purpose: Bank of eight registers, two read ports, one write port
// Assumes: One clock, asynchronous active-low reset
// Notes:   ZERO0 ties entry zero to zero (index registers)
`timescale 1ns/1ns
module ipua_regbank #(
  parameter int unsigned W     = 60,
  parameter bit          ZERO0 = 1'b0
) (
  input  wire logic         clock,
  input  wire logic         reset_n,
  input  wire logic         wr_en,
  input  wire logic [2:0]   wr_sel,
  input  wire logic [W-1:0] wr_data,
  input  wire logic [2:0]   rd_a_sel,
  output logic      [W-1:0] rd_a,
  input  wire logic [2:0]   rd_b_sel,
  output logic      [W-1:0] rd_b
);
  logic [W-1:0] mem [8];

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int n = 0; n < 8; n++) begin
        mem[n] <= '0;
      end
    end else if (wr_en && !(ZERO0 && wr_sel == 3'h0)) begin
      mem[wr_sel] <= wr_data;
    end
  end

  assign rd_a = (ZERO0 && rd_a_sel == 3'h0) ? '0 : mem[rd_a_sel];
  assign rd_b = (ZERO0 && rd_b_sel == 3'h0) ? '0 : mem[rd_b_sel];
endmodule // ipua_regbank

//--- verilog/ipua_alu.sv
// Purpose: Integer pack, unpack, sum and difference datapath slice
// Assumes: Issue logic presents one right-justified instruction per valid cycle
// Notes:   Results are written on the edge that takes the instruction
//
// Behaviour
// RULE1 - Opcode is six or nine leading bits
// RULE2 - Three-bit designators pick one of eight
// RULE3 - Combined j and k give shift count
// RULE4 - Long form carries 18-bit immediate
// RULE5 - Long form: opcode, i, j, then immediate
// RULE6 - Eight index registers, entry zero reads zero
// RULE7 - Eight 18-bit address registers
// RULE8 - Eight 60-bit operand registers take results
// RULE9 - Supervisor flag toggled only by exchange jumps
// RULE10 - Opcode 27 packs coefficient and exponent
// RULE11 - Pack keeps low 48 bits and sign
// RULE12 - Pack exponent from low 11 index bits
// RULE13 - Bias octal 2000, complement when negative
// RULE14 - Opcode 26 unpacks to operand and index
// RULE15 - Unpacked coefficient: upper 12 bits copy sign
// RULE16 - Unpacked exponent unbiased, sign-extended to 18
// RULE17 - Opcode 36 adds, no overflow
// RULE18 - Opcode 37 subtracts, no overflow
`timescale 1ns/1ns
module ipua_alu (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic        instr_valid,
  input  wire logic [29:0] instr,
  input  wire logic        instr_long,
  input  wire logic        pp_exchange,
  input  wire logic        a_wr_en,
  input  wire logic [2:0]  a_wr_sel,
  input  wire logic [17:0] a_wr_data,
  input  wire logic [2:0]  a_rd_sel,
  output logic      [17:0] a_rd_data,
  input  wire logic [2:0]  x_rd_sel,
  output logic      [59:0] x_rd_data,
  input  wire logic [2:0]  b_rd_sel,
  output logic      [17:0] b_rd_data,
  output logic      [8:0]  opcode9,
  output logic      [5:0]  shift_mask_count,
  output logic      [17:0] immediate,
  output logic             supervisor_flag,
  output logic             op_done
);
  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  // Short forms sit in the low 15 bits, long forms use all 30
  wire [29:0] word_al = instr_long ? instr : {instr[14:0], 15'h0};
  wire [5:0]  opc6    = word_al[ipua_pkg::OPC_LSB +: ipua_pkg::OPC_W]; // RULE1
  wire [8:0]  opc9    = word_al[ipua_pkg::I_LSB +: ipua_pkg::OPC9_W];  // RULE1
  wire [2:0]  dsg_i   = word_al[ipua_pkg::I_LSB +: ipua_pkg::DSG_W];   // RULE2 RULE5
  wire [2:0]  dsg_j   = word_al[ipua_pkg::J_LSB +: ipua_pkg::DSG_W];   // RULE2 RULE5
  wire [2:0]  dsg_k   = word_al[ipua_pkg::K_LSB +: ipua_pkg::DSG_W];   // RULE2
  wire [5:0]  jk      = {dsg_j, dsg_k};                                 // RULE3
  wire [17:0] imm     = instr[ipua_pkg::IMM_W-1:0];                     // RULE4 RULE5


  // ----------------------------------------------------------------
  // Opcode match
  // ----------------------------------------------------------------
  // Result-writing opcodes are short-form only; a long word never writes X
  wire short_ok  = instr_valid && !instr_long;
  wire long_ok   = instr_valid && instr_long;

  wire opc_pack   = opc6 == ipua_pkg::OPC_PACK;                         // RULE10
  wire opc_unpack = opc6 == ipua_pkg::OPC_UNPACK;                       // RULE14
  wire opc_add    = opc6 == ipua_pkg::OPC_IADD;                         // RULE17
  wire opc_sub    = opc6 == ipua_pkg::OPC_ISUB;                         // RULE18
  wire opc_exch   = opc6 == ipua_pkg::OPC_EXCH;                         // RULE9
  wire exch_lo    = dsg_i == ipua_pkg::OPC_EXCH_LO;                     // RULE9

  wire is_pack   = short_ok && opc_pack;
  wire is_unpack = short_ok && opc_unpack;
  wire is_add    = short_ok && opc_add;
  wire is_sub    = short_ok && opc_sub;

  // Exchange is a full-word instruction, so it arrives in the long form
  wire is_exch   = long_ok && opc_exch && exch_lo;

  // One write strobe for the bank, the shadow copy and the done pulse
  wire x_write   = is_pack || is_unpack || is_add || is_sub;            // RULE8
  wire b_write   = is_unpack;                                           // RULE14

  // ----------------------------------------------------------------
  // Register banks
  // ----------------------------------------------------------------
  logic [59:0] xj;
  logic [59:0] xk;
  logic [17:0] bj;
  logic [17:0] b_unused;
  logic [17:0] a_unused;
  logic [59:0] x_result;
  logic [17:0] b_result;

  ipua_regbank #(.W(60), .ZERO0(1'b0)) u_xbank (                       // RULE8
    .clock    (clock),
    .reset_n  (reset_n),
    .wr_en    (x_write),
    .wr_sel   (dsg_i),
    .wr_data  (x_result),
    .rd_a_sel (dsg_j),
    .rd_a     (xj),
    .rd_b_sel (dsg_k),
    .rd_b     (xk)
  );
  ipua_regbank #(.W(18), .ZERO0(1'b1)) u_bbank (                       // RULE6
    .clock    (clock),
    .reset_n  (reset_n),
    .wr_en    (b_write),
    .wr_sel   (dsg_j),
    .wr_data  (b_result),
    .rd_a_sel (dsg_j),
    .rd_a     (bj),
    .rd_b_sel (b_rd_sel),
    .rd_b     (b_unused)
  );
  ipua_regbank #(.W(18), .ZERO0(1'b0)) u_abank (                       // RULE7
    .clock    (clock),
    .reset_n  (reset_n),
    .wr_en    (a_wr_en),
    .wr_sel   (a_wr_sel),
    .wr_data  (a_wr_data),
    .rd_a_sel (a_rd_sel),
    .rd_a     (a_unused),
    .rd_b_sel (3'h0),
    .rd_b     ()
  );
  // Observation port reads a second X copy by muxing, bank has two ports only
  logic [59:0] xview [8];
  assign a_rd_data = a_unused;
  assign b_rd_data = b_unused;

  // ----------------------------------------------------------------
  // Pack
  // ----------------------------------------------------------------
  wire        xk_sign  = xk[ipua_pkg::SIGN_BIT];
  // Biased exponent: add octal 2000; negative one's complement values land below it
  wire [10:0] exp_bias = bj[ipua_pkg::EXP_W-1:0] ^ ipua_pkg::EXP_BIAS;  // RULE12 RULE13
  wire [11:0] se_field = {1'b0, exp_bias} ^ {12{xk_sign}};               // RULE13
  // Top bit of the complemented field is the coefficient sign itself
  wire [47:0] pack_coef = xk[ipua_pkg::COEF_W-1:0];                     // RULE11
  wire [59:0] pack_res  = {se_field, pack_coef};                        // RULE10 RULE11

  // ----------------------------------------------------------------
  // Unpack
  // ----------------------------------------------------------------
  wire [10:0] raw_exp  = xk[ipua_pkg::EXP_LSB +: ipua_pkg::EXP_W] ^ {11{xk_sign}}; // RULE16
  wire [10:0] ub_exp   = raw_exp ^ ipua_pkg::EXP_BIAS;                            // RULE16
  assign b_result = {{7{ub_exp[10]}}, ub_exp};                                    // RULE16
  wire [59:0] unpk_res = {{12{xk_sign}}, xk[ipua_pkg::COEF_W-1:0]};    // RULE14 RULE15

  // ----------------------------------------------------------------
  // Result select
  // ----------------------------------------------------------------
  wire [59:0] sum_res  = xj + xk;                                       // RULE17
  wire [59:0] diff_res = xj - xk;                                       // RULE18
  assign x_result = is_pack   ? pack_res :
                    is_unpack ? unpk_res :
                    is_add    ? sum_res  : diff_res;

  // Shadow copy of X for the observation port; written alongside the bank
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int n = 0; n < 8; n++) begin
        xview[n] <= ipua_pkg::X_RESET;
      end
    end else if (x_write) begin
      xview[dsg_i] <= x_result;                                        // RULE8
    end
  end
  assign x_rd_data = xview[x_rd_sel];

  // ----------------------------------------------------------------
  // Mode flag and decoded field outputs
  // ----------------------------------------------------------------
  wire next_flag = (is_exch || pp_exchange) ? !supervisor_flag : supervisor_flag; // RULE9

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      supervisor_flag  <= 1'b0;
      opcode9          <= 9'h0;
      shift_mask_count <= 6'h0;
      immediate        <= 18'h0;
      op_done          <= 1'b0;
    end else begin
      supervisor_flag  <= next_flag;                                   // RULE9
      op_done          <= x_write;                                     // RULE8
      if (instr_valid) begin
        opcode9          <= opc9;                                      // RULE1
        shift_mask_count <= jk;                                        // RULE3
        immediate        <= instr_long ? imm : 18'h0;                  // RULE4
      end
    end
  end
endmodule // ipua_alu

//--- dv/ipua_issue.sv
// Purpose: Issue-side model that presents instructions to the datapath
// Assumes: Caller changes go and word just after a rising edge
// Notes:   Idle bus shows the inverse of the last word, so stale data never looks valid
`timescale 1ns/1ns
module ipua_issue (
  input  wire logic        clock,
  input  wire logic        go,
  input  wire logic [29:0] word,
  input  wire logic        long_form,
  output logic             instr_valid,
  output logic      [29:0] instr,
  output logic             instr_long
);
  logic [29:0] last = 30'h0;
  always_ff @(posedge clock) if (go) last <= word;
  assign instr_valid = go;
  assign instr       = go ? word : ~last;
  assign instr_long  = long_form;
endmodule // ipua_issue

//--- dv/ipua_alu_sva.sv
// Purpose: Port-level assertions for the pack, unpack and sum slice
// Assumes: One clock, asynchronous active-low reset
// Notes:   Result-writing opcodes are recognised in the short form only
`timescale 1ns/1ns
module ipua_alu_sva (
  input wire logic        clock,
  input wire logic        reset_n,
  input wire logic        instr_valid,
  input wire logic [29:0] instr,
  input wire logic        instr_long,
  input wire logic        pp_exchange,
  input wire logic [2:0]  b_rd_sel,
  input wire logic [17:0] b_rd_data,
  input wire logic [8:0]  opcode9,
  input wire logic [5:0]  shift_mask_count,
  input wire logic [17:0] immediate,
  input wire logic        supervisor_flag,
  input wire logic        op_done
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire [5:0] opc = instr[14:9];
  wire act = instr_valid & ~instr_long & (opc inside {6'h16, 6'h17, 6'h1e, 6'h1f});
  wire xch = instr_valid & instr_long & (instr[29:21] == 9'h00b);
  wire [8:0]  lead9   = instr_long ? instr[29:21] : instr[14:6];
  wire [17:0] imm_exp = instr_long ? instr[17:0] : 18'h0;
  wire [5:0]  jk_fld  = instr[5:0];
  property p_b0; b_rd_sel == 3'h0 |-> b_rd_data == 18'h0; endproperty
  a_b0: assert property (p_b0) else $error("index zero not zero");
  property p_done; act |=> op_done; endproperty
  a_done: assert property (p_done) else $error("no done pulse");
  property p_nodone; op_done |-> $past(act); endproperty
  a_nodone: assert property (p_nodone) else $error("stray done pulse");
  property p_pp; pp_exchange |=> supervisor_flag != $past(supervisor_flag); endproperty
  a_pp: assert property (p_pp) else $error("flag did not toggle");
  property p_hold; !pp_exchange && !xch |=> $stable(supervisor_flag); endproperty
  a_hold: assert property (p_hold) else $error("flag moved");
  property p_opc;
    instr_valid |=> opcode9 == $past(lead9);
  endproperty
  a_opc: assert property (p_opc) else $error("opcode field wrong");
  property p_shm; instr_valid && !instr_long |=> shift_mask_count == $past(jk_fld); endproperty
  a_shm: assert property (p_shm) else $error("shift count wrong");
  property p_imm; instr_valid |=> immediate == $past(imm_exp); endproperty
  a_imm: assert property (p_imm) else $error("immediate wrong");
  c_act: cover property (act);
  c_xch: cover property (xch);
  c_both: cover property (xch && pp_exchange);
endmodule // ipua_alu_sva

//--- dv/ipua_alu_bench.sv
// Purpose: Self-checking bench for the pack, unpack and sum slice
// Assumes: Operands are built from reset zeros by the slice itself
// Notes:   No load path exists, so low 48 operand bits stay zero
`timescale 1ns/1ns
module ipua_alu_bench;
  logic        clock, reset_n, go, long_form, pp_exchange, a_wr_en, instr_valid, instr_long;
  logic        supervisor_flag, op_done;
  logic [29:0] word, instr;
  logic [2:0]  a_wr_sel, a_rd_sel, x_rd_sel, b_rd_sel;
  logic [17:0] a_wr_data, a_rd_data, b_rd_data, immediate;
  logic [59:0] x_rd_data;
  logic [8:0]  opcode9;
  logic [5:0]  shift_mask_count;
  logic [59:0] xm [8];
  logic [17:0] bm [8];
  int          num_errors, checked;
  ipua_issue u_ipua_issue (.clock(clock), .go(go), .word(word), .long_form(long_form),
    .instr_valid(instr_valid), .instr(instr), .instr_long(instr_long));
  ipua_alu u_ipua_alu (.clock(clock), .reset_n(reset_n), .instr_valid(instr_valid),
    .instr(instr), .instr_long(instr_long), .pp_exchange(pp_exchange), .a_wr_en(a_wr_en),
    .a_wr_sel(a_wr_sel), .a_wr_data(a_wr_data), .a_rd_sel(a_rd_sel), .a_rd_data(a_rd_data),
    .x_rd_sel(x_rd_sel), .x_rd_data(x_rd_data), .b_rd_sel(b_rd_sel), .b_rd_data(b_rd_data),
    .opcode9(opcode9), .shift_mask_count(shift_mask_count), .immediate(immediate),
    .supervisor_flag(supervisor_flag), .op_done(op_done));
  task automatic check(input logic [59:0] seen, input logic [59:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Reference pack: biased exponent, sign and exponent complemented together when negative
  function automatic logic [59:0] pack(input logic [59:0] c, input logic [17:0] e);
    logic [11:0] t;
    t = {1'b0, e[10:0] ^ ipua_pkg::EXP_BIAS};
    return {c[59] ? ~t : t, c[47:0]};
  endfunction
  function automatic logic [17:0] uexp(input logic [59:0] v);
    logic [10:0] f;
    f = (v[59] ? ~v[58:48] : v[58:48]) ^ ipua_pkg::EXP_BIAS;
    return {{7{f[10]}}, f};
  endfunction
  task automatic run(input logic [5:0] opc, input logic [2:0] i, j, k);
    logic [59:0] ex;
    logic [17:0] eb;
    logic        wr;
    wr = 1'b1;
    eb = bm[j];
    case (opc)
      ipua_pkg::OPC_PACK:   ex = pack(xm[k], bm[j]);
      ipua_pkg::OPC_UNPACK: begin
        ex = {{12{xm[k][59]}}, xm[k][47:0]};
        if (j != 3'h0) eb = uexp(xm[k]);
      end
      ipua_pkg::OPC_IADD:   ex = xm[j] + xm[k];
      ipua_pkg::OPC_ISUB:   ex = xm[j] - xm[k];
      default: begin
        ex = xm[i];
        wr = 1'b0;
      end
    endcase
    @(posedge clock);
    go        <= 1'b1;
    long_form <= 1'b0;
    word      <= {15'h0, opc, i, j, k};
    x_rd_sel  <= i;
    b_rd_sel  <= j;
    @(posedge clock);
    go <= 1'b0;
    @(negedge clock);
    check(op_done, wr);
    check(x_rd_data, ex);
    check(b_rd_data, eb);
    check(opcode9, {opc, i});
    check(shift_mask_count, {j, k});
    check(immediate, 18'h0);
    xm[i] = ex;
    bm[j] = eb;
  endtask
  task automatic exchanges();
    @(posedge clock);
    go        <= 1'b1;
    long_form <= 1'b1;
    word      <= {9'h00b, 3'h5, 18'h2a5a5};
    @(posedge clock);
    go          <= 1'b0;
    pp_exchange <= 1'b1;
    @(negedge clock);
    check(supervisor_flag, 1'b1);
    check(opcode9, 9'h00b);
    check(immediate, 18'h2a5a5);
    @(posedge clock);
    go <= 1'b1;
    @(negedge clock);
    check(supervisor_flag, 1'b0);
    @(posedge clock);
    go          <= 1'b0;
    pp_exchange <= 1'b0;
    @(negedge clock);
    check(supervisor_flag, 1'b1);
  endtask
  task automatic addr_regs();
    for (int n = 0; n < 9; n++) begin
      @(posedge clock);
      a_wr_en   <= (n < 8);
      a_wr_sel  <= n[2:0];
      a_wr_data <= 18'h15a00 + 18'(n);
    end
    for (int n = 0; n < 8; n++) begin
      @(posedge clock);
      a_rd_sel <= n[2:0];
      @(negedge clock);
      check(a_rd_data, 18'h15a00 + 18'(n));
    end
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d, errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // Watchdog: a hang counts as a mismatch
  initial begin
    #1000000;
    num_errors++;
    tally_and_finish();
  end
  initial begin
    {reset_n, go, long_form, pp_exchange, a_wr_en} = 5'h0;
    {word, a_wr_sel, a_rd_sel, x_rd_sel, b_rd_sel, a_wr_data} = 60'h0;
    xm = '{default: 60'h0};
    bm = '{default: 18'h0};
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    @(negedge clock);
    check(supervisor_flag, 1'b0);
    run(ipua_pkg::OPC_PACK, 3'h1, 3'h0, 3'h0);
    run(ipua_pkg::OPC_ISUB, 3'h2, 3'h0, 3'h1);
    run(ipua_pkg::OPC_UNPACK, 3'h3, 3'h1, 3'h2);
    run(ipua_pkg::OPC_PACK, 3'h4, 3'h1, 3'h3);
    run(ipua_pkg::OPC_UNPACK, 3'h5, 3'h0, 3'h4);
    run(ipua_pkg::OPC_IADD, 3'h6, 3'h4, 3'h4);
    run(ipua_pkg::OPC_UNPACK, 3'h7, 3'h2, 3'h1);
    run(6'h20, 3'h7, 3'h2, 3'h6);
    exchanges();
    addr_regs();
    tally_and_finish();
  end
endmodule // ipua_alu_bench
bind ipua_alu ipua_alu_sva u_ipua_alu_sva (.clock(clock), .reset_n(reset_n),
  .instr_valid(instr_valid), .instr(instr), .instr_long(instr_long),
  .pp_exchange(pp_exchange), .b_rd_sel(b_rd_sel), .b_rd_data(b_rd_data),
  .opcode9(opcode9), .shift_mask_count(shift_mask_count), .immediate(immediate),
  .supervisor_flag(supervisor_flag), .op_done(op_done));
